// ### qwd_pkg.sv
// Purpose: shared constants and types for the quadrature watchdog block
// Assumes: one 20 MHz core clock
// Notes: no software-reachable registers; controls are plain ports
package qwd_pkg;
    localparam int QWD_WIDTH = 16;
    localparam int QWD_PRESCALE = 64;
    localparam int QWD_PRE_W = 6;
    localparam logic [QWD_WIDTH-1:0] QWD_COUNT_RST = 16'h0000;
    localparam logic [QWD_PRE_W-1:0] QWD_PRE_RST = 6'h00;
    localparam logic [QWD_PRE_W-1:0] QWD_PRE_LAST = 6'h3F;
    localparam logic [1:0] QWD_MODE_QUAD = 2'h0;
    localparam logic [1:0] QWD_MODE_DIR_CNT = 2'h1;
    localparam logic [1:0] QWD_MODE_UP_CNT = 2'h2;
    localparam logic [1:0] QWD_MODE_DN_CNT = 2'h3;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
    } qwd_phases_t;

    typedef struct packed {
        logic wd_flag;
        logic phase_err_flag;
        logic irq;
    } qwd_status_t;
endpackage

// ### qwd_mode_adapter.sv
// Purpose: encoder mode adapter, checks phase transitions and makes clock events
// Assumes: phase inputs already synchronised to core_clk
// Notes: a both-phase change in one sample is illegal in every mode
`timescale 1ns/1ps
module qwd_mode_adapter
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [1:0] mode,
    input wire qwd_pkg::qwd_phases_t phases,
    output logic qclk_event,
    output logic illegal_event
);
    import qwd_pkg::*;

    qwd_phases_t prev_q;
    logic a_chg;
    logic b_chg;
    logic init_q;

    assign a_chg = phases.phase_a ^ prev_q.phase_a;
    assign b_chg = phases.phase_b ^ prev_q.phase_b;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prev_q <= '0;
            init_q <= 1'b0;
        end
        else
        begin
            prev_q <= phases;
            init_q <= 1'b1;
        end
    end

    // quadrature: every single-phase edge counts; others: rising phase a is the clock
    always_comb
    begin
        qclk_event = 1'b0;
        illegal_event = 1'b0;
        if (init_q)
        begin
            unique case (mode)
                QWD_MODE_QUAD:
                begin
                    qclk_event = a_chg ^ b_chg;
                    illegal_event = a_chg & b_chg;
                end
                QWD_MODE_DIR_CNT:
                begin
                    qclk_event = a_chg & phases.phase_a;
                    illegal_event = a_chg & b_chg;
                end
                QWD_MODE_UP_CNT, QWD_MODE_DN_CNT:
                begin
                    qclk_event = a_chg & phases.phase_a;
                    // phase b must stay quiet in single-count modes
                    illegal_event = b_chg;
                end
            endcase
        end
    end
endmodule // qwd_mode_adapter

// ### qwd_watchdog.sv
// Purpose: quadrature watchdog and phase error reporting of the position decoder
// Assumes: encoder pins are asynchronous; software sits beyond plain ports
// Notes: flags are sticky; set beats clear in the same cycle
`timescale 1ns/1ps
module qwd_watchdog #(
    parameter int WIDTH = qwd_pkg::QWD_WIDTH
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic encoder_phase_a_input,
    input wire logic encoder_phase_b_input,
    input wire logic [1:0] mode,
    input wire logic wd_enable,
    input wire logic [WIDTH-1:0] wd_period,
    input wire logic wd_flag_clear,
    input wire logic phase_err_clear,
    input wire logic irq_enable,
    output logic [WIDTH-1:0] wd_count,
    output logic wd_timeout,
    output qwd_pkg::qwd_status_t status
);
    import qwd_pkg::*;

    logic [1:0] a_sync_q;
    logic [1:0] b_sync_q;
    qwd_phases_t phases;
    logic qclk_event;
    logic illegal_event;
    logic [QWD_PRE_W-1:0] pre_q;
    logic tick;
    logic [WIDTH-1:0] count_q;
    logic match;
    logic timeout_q;
    logic wd_flag_q;
    logic err_flag_q;
    logic irq_q;
    logic [QWD_PRE_W-1:0] pre_d;
    logic [WIDTH-1:0] count_d;
    logic timeout_d;
    logic wd_flag_d;
    logic err_flag_d;

    // two-stage synchronisers for the encoder pins, one per pin
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            a_sync_q <= 2'h0;
        end
        else
        begin
            a_sync_q <= {a_sync_q[0], encoder_phase_a_input};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            b_sync_q <= 2'h0;
        end
        else
        begin
            b_sync_q <= {b_sync_q[0], encoder_phase_b_input};
        end
    end

    assign phases.phase_a = a_sync_q[1];
    assign phases.phase_b = b_sync_q[1];

    qwd_mode_adapter u_adapter
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .mode(mode),
        .phases(phases),
        .qclk_event(qclk_event),
        .illegal_event(illegal_event)
    );

    // divide-by-64 tick from the core clock
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pre_q <= QWD_PRE_RST;
        end
        else
        begin
            pre_q <= pre_d;
        end
    end

    assign tick = (pre_q == QWD_PRE_LAST);
    assign match = (count_q == wd_period);

    assign pre_d = pre_q + 6'h01;
    assign timeout_d = wd_enable && tick && match && !qclk_event;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= QWD_COUNT_RST;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    // an event beats a tick, so an event on a match tick clears the count and blocks the timeout
    always_comb
    begin
        count_d = count_q;
        if (!wd_enable || qclk_event)
        begin
            count_d = QWD_COUNT_RST;
        end
        else if (tick)
        begin
            if (match)
            begin
                count_d = QWD_COUNT_RST;
            end
            else
            begin
                count_d = count_q + WIDTH'(1);
            end
        end
    end

    // one-cycle timeout pulse on a match tick with no event
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timeout_q <= 1'b0;
        end
        else
        begin
            timeout_q <= timeout_d;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wd_flag_q <= 1'b0;
        end
        else
        begin
            wd_flag_q <= wd_flag_d;
        end
    end

    // set wins when a timeout meets a clear
    always_comb
    begin
        wd_flag_d = wd_flag_q;
        if (timeout_q)
        begin
            wd_flag_d = 1'b1;
        end
        else if (wd_flag_clear)
        begin
            wd_flag_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            err_flag_q <= 1'b0;
        end
        else
        begin
            err_flag_q <= err_flag_d;
        end
    end

    // set wins when an illegal step meets a clear
    always_comb
    begin
        err_flag_d = err_flag_q;
        if (illegal_event)
        begin
            err_flag_d = 1'b1;
        end
        else if (phase_err_clear)
        begin
            err_flag_d = 1'b0;
        end
    end

    // single decoder interrupt carries both sources
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_enable && (wd_flag_q || err_flag_q);
        end
    end

    assign wd_count = count_q;
    assign wd_timeout = timeout_q;
    assign status.wd_flag = wd_flag_q;
    assign status.phase_err_flag = err_flag_q;
    assign status.irq = irq_q;
endmodule // qwd_watchdog

// ### qwd_watchdog_asserts.sv
// Purpose: port checks of qwd_watchdog
// Assumes: prescaler free-runs from reset
// Notes: tk mirrors the divide-by-64 tick
`timescale 1ns/1ps
module qwd_watchdog_asserts #(
    parameter int WIDTH = 16
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic wd_enable,
    input wire logic [WIDTH-1:0] wd_period,
    input wire logic wd_flag_clear,
    input wire logic phase_err_clear,
    input wire logic irq_enable,
    input wire logic [WIDTH-1:0] wd_count,
    input wire logic wd_timeout,
    input wire qwd_pkg::qwd_status_t status
);
    import qwd_pkg::*;
    logic [5:0] pre_q;
    logic tk;
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n) pre_q <= QWD_PRE_RST;
        else pre_q <= pre_q + 6'h01;
    assign tk = pre_q == QWD_PRE_LAST;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_count_on_tick: assert property ($changed(wd_count) && wd_count != 0 |->
        $past(tk) && wd_count == $past(wd_count) + 1) else $error("count step");
    a_timeout_cause: assert property (wd_timeout |-> $past(tk) && wd_count == 0 &&
        $past(wd_count) == $past(wd_period)) else $error("timeout cause");
    a_timeout_pulse: assert property (wd_timeout |=> !wd_timeout) else $error("pulse");
    a_idle_off: assert property (!wd_enable |=> wd_count == 0 && !wd_timeout) else $error("off");
    a_flag_set: assert property (wd_timeout |=> status.wd_flag) else $error("flag set");
    a_flag_hold: assert property (status.wd_flag && !wd_flag_clear |=> status.wd_flag)
        else $error("flag hold");
    a_flag_clear: assert property (wd_flag_clear && !wd_timeout |=> !status.wd_flag)
        else $error("flag clear");
    a_err_hold: assert property (status.phase_err_flag && !phase_err_clear |=>
        status.phase_err_flag) else $error("err hold");
    a_irq_merged: assert property (1'b1 |=> status.irq ==
        $past((status.wd_flag | status.phase_err_flag) & irq_enable)) else $error("irq");
    cover property (wd_timeout);
    cover property (status.phase_err_flag && status.irq);
    cover property (status.wd_flag ##1 !status.wd_flag);
endmodule // qwd_watchdog_asserts
bind qwd_watchdog qwd_watchdog_asserts #(.WIDTH(WIDTH)) chk_u (.core_clk(core_clk),
    .reset_n(reset_n), .wd_enable(wd_enable), .wd_period(wd_period),
    .wd_flag_clear(wd_flag_clear), .phase_err_clear(phase_err_clear),
    .irq_enable(irq_enable), .wd_count(wd_count), .wd_timeout(wd_timeout), .status(status));

// ### qwd_encoder_model.sv
// Purpose: incremental encoder model
// Assumes: one gray step per step pulse
// Notes: glitch flips both phases at once
`timescale 1ns/1ps
module qwd_encoder_model
(
    input wire logic core_clk,
    input wire logic step,
    input wire logic glitch,
    output qwd_pkg::qwd_phases_t ph
);
    import qwd_pkg::*;
    qwd_phases_t pos_q = '0;
    assign ph = pos_q;
    always @(posedge core_clk)
        if (glitch) pos_q <= ~pos_q;
        else if (step) pos_q <= {~pos_q.phase_b, pos_q.phase_a};
endmodule // qwd_encoder_model

// ### qwd_watchdog_tb_top.sv
// Purpose: scenario bench of qwd_watchdog
// Assumes: 20 MHz core clock
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module qwd_watchdog_tb_top;
    import qwd_pkg::*;
    logic core_clk = 0, reset_n = 0, step = 0, glitch = 0, en = 0, fclr = 0, eclr = 0, ien = 0;
    logic [1:0] mode = 2'h0;
    logic [15:0] per = 16'h0002, cnt;
    logic tmo;
    qwd_status_t st;
    qwd_phases_t ph;
    int err_count = 0, check_count = 0, tos = 0, b;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (tmo === 1'b1) tos++;
    qwd_encoder_model enc_u (.core_clk(core_clk), .step(step), .glitch(glitch), .ph(ph));
    qwd_watchdog dut_u (.core_clk(core_clk), .reset_n(reset_n), .encoder_phase_a_input(ph.phase_a),
        .encoder_phase_b_input(ph.phase_b), .mode(mode), .wd_enable(en), .wd_period(per),
        .wd_flag_clear(fclr), .phase_err_clear(eclr), .irq_enable(ien), .wd_count(cnt),
        .wd_timeout(tmo), .status(st));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic t_timeout;
        int n = 0;
        en = 1; ien = 1; per = 16'h0002;
        while (tmo !== 1'b1 && n < 400)
        begin
            @(posedge core_clk); #1; n++;
        end
        chk(16'(n > 128 && n < 194), 16'h1);
        chk(cnt, 16'h0);
        @(posedge core_clk); #1 chk(16'(st.wd_flag), 16'h1);
        @(posedge core_clk); #1 chk(16'(st.irq), 16'h1);
        cyc(1); fclr = 1; en = 0;
        cyc(1); fclr = 0;
        chk(16'(st.wd_flag), 16'h0);
    endtask
    task automatic t_events;
        en = 1; per = 16'h0005; b = tos;
        repeat (20)
        begin
            step = 1; cyc(1); step = 0; cyc(39);
        end
        chk(16'(tos - b), 16'h0);
        chk(16'(cnt <= 16'h1), 16'h1);
        chk(16'(st.phase_err_flag), 16'h0);
    endtask
    task automatic t_period;
        en = 0; per = 16'h0000; b = tos;
        cyc(300);
        chk(16'(tos - b), 16'h0);
        en = 1; cyc(192); en = 0;
        chk(16'((tos - b) inside {2, 3}), 16'h1);
        cyc(2);
        fclr = 1;
        cyc(1);
        fclr = 0;
        cyc(2);
        chk(16'(st.wd_flag), 16'h0);
        chk(16'(st.irq), 16'h0);
    endtask
    task automatic t_glitch;
        for (int m = 0; m < 4; m++)
        begin
            mode = 2'(m); ien = m[0]; glitch = 1; cyc(1); glitch = 0; cyc(6);
            chk(16'(st.phase_err_flag), 16'h1);
            chk(16'(st.irq), 16'(ien));
            eclr = 1; cyc(1); eclr = 0; cyc(2);
            chk(16'(st.phase_err_flag), 16'h0);
            chk(16'(st.irq), 16'h0);
        end
    endtask
    initial
    begin
        cyc(8); reset_n = 1; cyc(2);
        t_timeout(); t_events(); t_period(); t_glitch();
        end_of_test();
    end
    initial
    begin
        #200000; err_count++;
        end_of_test();
    end
endmodule // qwd_watchdog_tb_top
